// File: rtl/lsal_core.v
// Purpose: sticky limit status, alert masking and shared pin select
// Assumes: all inputs come from logic on sys_clk; reads/writes are
//          one-cycle strobes from the serial register interface
// Notes:   a status read returns the flags and then clears those
//          whose condition has gone away; a live condition wins
//          over the clear in the same cycle; writes to the status
//          registers are ignored
`timescale 1ns/100ps
`include "lsal_regs.vh"

module lsal_core (
    input  wire                    sys_clk,
    input  wire                    rst_b,
    input  wire [`LSAL_ADDR_W-1:0] reg_addr,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    input  wire [`LSAL_DATA_W-1:0] reg_wdata,
    output reg  [`LSAL_DATA_W-1:0] reg_rdata,
    input  wire                    meas_valid,
    input  wire [`LSAL_CHAN_W-1:0] meas_chan,
    input  wire [`LSAL_DATA_W-1:0] meas_value,
    input  wire [`LSAL_DATA_W-1:0] meas_high_limit,
    input  wire [`LSAL_DATA_W-1:0] meas_low_limit,
    input  wire                    tach_one_slow,
    input  wire                    tach_two_slow,
    input  wire                    tach_three_slow,
    input  wire                    tach_four_slow,
    input  wire                    diode_one_fault,
    input  wire                    diode_two_fault,
    input  wire                    critical_temp_limit,
    input  wire                    pwm_drive_in,
    output reg                     alert_n,
    output reg                     second_drive_output
);

    // address decode shared by reads and writes
    function addr_hit;
        input [`LSAL_ADDR_W-1:0] addr;
        input [`LSAL_ADDR_W-1:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    reg  [`LSAL_CHAN_N-1:0] chan_out;
    reg  [`LSAL_SRC_N-1:0]  flags;
    reg  [`LSAL_DATA_W-1:0] alert_block_primary;
    reg  [`LSAL_DATA_W-1:0] alert_block_secondary;
    reg                     alert_pin_sel;
    reg  [`LSAL_DATA_W-1:0] next_rdata;

    wire                    cmp_out;
    wire                    cmp_signed;
    wire [`LSAL_SRC_N-1:0]  live_cond;
    wire [`LSAL_SRC_N-1:0]  flag_clear;
    wire [`LSAL_SRC_N-1:0]  next_flags;
    wire [`LSAL_SRC_N-1:0]  eff_block;
    wire [`LSAL_DATA_W-1:0] limit_flags_primary;
    wire [`LSAL_DATA_W-1:0] limit_flags_secondary;
    wire                    rd_primary;
    wire                    rd_secondary;
    wire                    next_alert_n;
    wire                    next_pin;
    wire                    wr_block_pri;
    wire                    wr_block_sec;
    wire                    wr_config;
    wire [`LSAL_DATA_W-1:0] cfg_rdata;
    wire [`LSAL_SRC_N-1:0]  alert_src;

    // temperature channels compare as signed values
    assign cmp_signed = (meas_chan == `LSAL_CH_REMOTE1) ||
                        (meas_chan == `LSAL_CH_LOCAL) ||
                        (meas_chan == `LSAL_CH_REMOTE2);

    lsal_limit_cmp u_cmp (
        .value        (meas_value),
        .high_limit   (meas_high_limit),
        .low_limit    (meas_low_limit),
        .is_signed    (cmp_signed),
        .out_of_limit (cmp_out)
    );

    // latest comparison result per analog channel
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            chan_out <= `LSAL_RST_CHAN;
        end else if (meas_valid) begin
            chan_out[meas_chan] <= cmp_out;
        end
    end

    // live conditions: bits 6..0 primary, 14..7 secondary
    assign live_cond = {
        diode_two_fault,
        diode_one_fault,
        tach_four_slow,
        tach_three_slow,
        tach_two_slow,
        tach_one_slow,
        critical_temp_limit,
        chan_out[`LSAL_CH_12V],
        chan_out[`LSAL_CH_REMOTE2],
        chan_out[`LSAL_CH_LOCAL],
        chan_out[`LSAL_CH_REMOTE1],
        chan_out[`LSAL_CH_5V],
        chan_out[`LSAL_CH_SUPPLY],
        chan_out[`LSAL_CH_CORE],
        chan_out[`LSAL_CH_2V5]
    };

    assign rd_primary   = reg_rd && addr_hit(reg_addr, `LSAL_ADDR_FLAGS_PRI);
    assign rd_secondary = reg_rd && addr_hit(reg_addr, `LSAL_ADDR_FLAGS_SEC);

    // status registers take no writes
    assign wr_block_pri = reg_wr && addr_hit(reg_addr, `LSAL_ADDR_BLOCK_PRI);
    assign wr_block_sec = reg_wr && addr_hit(reg_addr, `LSAL_ADDR_BLOCK_SEC);
    assign wr_config    = reg_wr && addr_hit(reg_addr, `LSAL_ADDR_CONFIG3);

    // sticky flags: a live condition always wins over a read clear
    genvar i;
    generate
        for (i = 0; i < `LSAL_SRC_N; i = i + 1) begin : g_flag
            if (i < `LSAL_PRI_SRC_N) begin : g_pri
                assign flag_clear[i] = rd_primary;
            end else begin : g_sec
                assign flag_clear[i] = rd_secondary;
            end
            assign next_flags[i] = live_cond[i] |
                                   (flags[i] & ~flag_clear[i]);
        end
    endgenerate

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            flags <= `LSAL_RST_FLAGS;
        end else begin
            flags <= next_flags;
        end
    end

    assign limit_flags_secondary = flags[`LSAL_SRC_N-1:`LSAL_PRI_SRC_N];
    assign limit_flags_primary   = {
        |limit_flags_secondary,
        flags[`LSAL_PRI_SRC_N-1:0]
    };

    // mask registers and pin select
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            alert_block_primary   <= `LSAL_RST_BYTE;
            alert_block_secondary <= `LSAL_RST_BYTE;
            alert_pin_sel         <= `LSAL_RST_BIT;
        end else begin
            if (wr_block_pri) begin
                alert_block_primary <= reg_wdata;
            end
            if (wr_block_sec) begin
                alert_block_secondary <= reg_wdata;
            end
            if (wr_config) begin
                alert_pin_sel <= reg_wdata[`LSAL_ALERT_SEL_BIT];
            end
        end
    end

    // secondary mask only counts while primary bit 7 is set
    assign eff_block = {
        alert_block_secondary &
            {`LSAL_SEC_SRC_N{alert_block_primary[`LSAL_SEC_ENABLE_BIT]}},
        alert_block_primary[`LSAL_PRI_SRC_N-1:0]
    };

    // one bit per source that may pull the alert low
    assign alert_src    = next_flags & ~eff_block;
    // sticky flags keep the alert low until the read clears them
    assign next_alert_n = ~|alert_src;
    assign next_pin     = alert_pin_sel ? next_alert_n : pwm_drive_in;

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            alert_n <= `LSAL_RST_ALERT_N;
        end else begin
            alert_n <= next_alert_n;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            second_drive_output <= `LSAL_RST_BIT;
        end else begin
            second_drive_output <= next_pin;
        end
    end

    assign cfg_rdata = {{(`LSAL_DATA_W-1){1'b0}}, alert_pin_sel};

    // read data: value before this read's clear takes effect
    always @* begin
        next_rdata = `LSAL_RST_BYTE;
        if (addr_hit(reg_addr, `LSAL_ADDR_FLAGS_PRI)) begin
            next_rdata = limit_flags_primary;
        end
        if (addr_hit(reg_addr, `LSAL_ADDR_FLAGS_SEC)) begin
            next_rdata = limit_flags_secondary;
        end
        if (addr_hit(reg_addr, `LSAL_ADDR_BLOCK_PRI)) begin
            next_rdata = alert_block_primary;
        end
        if (addr_hit(reg_addr, `LSAL_ADDR_BLOCK_SEC)) begin
            next_rdata = alert_block_secondary;
        end
        if (addr_hit(reg_addr, `LSAL_ADDR_CONFIG3)) begin
            next_rdata = cfg_rdata;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rdata <= `LSAL_RST_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // lsal_core

// File: shared/lsal_regs.vh
// Purpose: constants for the limit status and alert logic
// Assumes: byte-wide register port, one clock (sys_clk)
// Notes:   offsets are the device register addresses
//
// Overview of operation
// - Primary bit 7 summarises any secondary flag
// - Primary bits 6..4: remote2, local, remote1 temperature
// - Primary bits 3..0: 5V, supply, core, 2.5V
// - Secondary bits 7,6: diode two, one faults
// - Secondary bits 5..2: tachometers four..one slow
// - Secondary bit 1 overtemperature, bit 0 12V
// - Flags sticky until condition gone and read
// - Alert held while out of limit, until read
// - Masking blocks alert only, flag still sets
// - Primary mask bit 7 enables secondary mask
// - Primary mask bits 6..0 block primary sources
// - Secondary mask bits 7..0 block secondary sources
// - Shared pin is drive output unless config bit0
// - High limit uses greater; low uses less-or-equal
// - Flag follows latest comparison on its channel

`ifndef LSAL_REGS_VH
`define LSAL_REGS_VH

`define LSAL_ADDR_W          8
`define LSAL_DATA_W          8

// register addresses
`define LSAL_ADDR_FLAGS_PRI  8'h41
`define LSAL_ADDR_FLAGS_SEC  8'h42
`define LSAL_ADDR_BLOCK_PRI  8'h74
`define LSAL_ADDR_BLOCK_SEC  8'h75
`define LSAL_ADDR_CONFIG3    8'h78

// reset values
`define LSAL_RST_BYTE        8'h00
`define LSAL_RST_FLAGS       15'h0000
`define LSAL_RST_CHAN        8'h00
`define LSAL_RST_BIT         1'b0
`define LSAL_RST_ALERT_N     1'b1

// field positions
`define LSAL_SUMMARY_BIT     7
`define LSAL_SEC_ENABLE_BIT  7
`define LSAL_ALERT_SEL_BIT   0
`define LSAL_PRI_SRC_N       7
`define LSAL_SEC_SRC_N       8
`define LSAL_SRC_N           15

// analog measurement channel codes
`define LSAL_CHAN_W          3
`define LSAL_CHAN_N          8
`define LSAL_CH_2V5          3'h0
`define LSAL_CH_CORE         3'h1
`define LSAL_CH_SUPPLY       3'h2
`define LSAL_CH_5V           3'h3
`define LSAL_CH_12V          3'h4
`define LSAL_CH_REMOTE1      3'h5
`define LSAL_CH_LOCAL        3'h6
`define LSAL_CH_REMOTE2      3'h7

`endif

// File: rtl/lsal_limit_cmp.v
// Purpose: out-of-limit comparison of one measurement
// Assumes: temperature values are two's complement
// Notes:   purely combinational
`timescale 1ns/100ps
`include "lsal_regs.vh"

module lsal_limit_cmp (
    input  wire [`LSAL_DATA_W-1:0] value,
    input  wire [`LSAL_DATA_W-1:0] high_limit,
    input  wire [`LSAL_DATA_W-1:0] low_limit,
    input  wire                    is_signed,
    output wire                    out_of_limit
);
    wire over_u;
    wire under_u;
    wire over_s;
    wire under_s;

    assign over_u  = value > high_limit;
    assign under_u = value <= low_limit;
    assign over_s  = $signed(value) > $signed(high_limit);
    assign under_s = $signed(value) <= $signed(low_limit);

    assign out_of_limit = is_signed ? (over_s | under_s) : (over_u | under_u);
endmodule // lsal_limit_cmp

// File: dv/lsal_core_chk.sv
// Purpose: port assertions for lsal_core
// Assumes: masks and config shadowed from writes
// Notes:   bound after the module
`timescale 1ns/100ps
module lsal_core_chk (
    input wire       sys_clk,
    input wire       rst_b,
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire       tach_one_slow,
    input wire       tach_two_slow,
    input wire       tach_three_slow,
    input wire       tach_four_slow,
    input wire       diode_one_fault,
    input wire       diode_two_fault,
    input wire       critical_temp_limit,
    input wire       pwm_drive_in,
    input wire       alert_n,
    input wire       second_drive_output
);
    reg  [7:0] m1;
    reg  [7:0] m2;
    reg        cfg;
    wire [6:0] lvl = {diode_two_fault, diode_one_fault, tach_four_slow, tach_three_slow,
                      tach_two_slow, tach_one_slow, critical_temp_limit};
    wire [6:0] eff = m2[7:1] & {7{m1[7]}};
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            m1  <= 8'h00;
            m2  <= 8'h00;
            cfg <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == 8'h74) m1 <= reg_wdata;
            if (reg_addr == 8'h75) m2 <= reg_wdata;
            if (reg_addr == 8'h78) cfg <= reg_wdata[0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    src_alert_a: assert property ((lvl & ~eff) != 7'h00 && !reg_wr |=> !alert_n)
        else $error("alert missing for unmasked source");
    all_masked_a: assert property (m1 == 8'hff && m2 == 8'hff && !reg_wr |=> alert_n)
        else $error("alert with every source masked");
    sec_enable_a: assert property (lvl != 7'h00 && !m1[7] && !reg_wr |=> !alert_n)
        else $error("secondary mask acted while disabled");
    mask1_read_a: assert property (reg_rd && reg_addr == 8'h74 |=> reg_rdata == m1)
        else $error("primary mask readback wrong");
    mask2_read_a: assert property (reg_rd && reg_addr == 8'h75 |=> reg_rdata == m2)
        else $error("secondary mask readback wrong");
    sticky_flag_a: assert property ((lvl != 7'h00) ##1 (reg_rd && reg_addr == 8'h42) |=>
        (reg_rdata[7:1] & $past(lvl, 2)) == $past(lvl, 2)) else $error("flag not held");
    summary_bit_a: assert property ((lvl != 7'h00) ##1 (reg_rd && reg_addr == 8'h41) |=>
        reg_rdata[7]) else $error("summary flag clear");
    pin_alert_a: assert property (cfg && $past(cfg) |-> second_drive_output == alert_n)
        else $error("shared pin not alert");
    pin_drive_a: assert property (!cfg && !$past(cfg) && $past(rst_b) |->
        second_drive_output == $past(pwm_drive_in)) else $error("shared pin not drive");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
endmodule // lsal_core_chk
bind lsal_core lsal_core_chk i_lsal_core_chk (.sys_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .tach_one_slow, .tach_two_slow, .tach_three_slow, .tach_four_slow,
    .diode_one_fault, .diode_two_fault, .critical_temp_limit, .pwm_drive_in, .alert_n,
    .second_drive_output);

// File: dv/lsal_host.sv
// Purpose: host side of the register port
// Assumes: one-cycle strobes, data one cycle later
// Notes:   idle address and data are scrambled
`timescale 1ns/100ps
module lsal_host (
    input  wire       sys_clk,
    output reg  [7:0] reg_addr,
    output reg        reg_wr,
    output reg        reg_rd,
    output reg  [7:0] reg_wdata,
    input  wire [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    task acc(input w, input [7:0] a, input [7:0] d, output [7:0] q);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge sys_clk);
        q = reg_rdata;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule // lsal_host

// File: dv/lsal_core_test.sv
// Purpose: self-checking bench for lsal_core
// Assumes: inputs driven on the falling edge
// Notes:   random limits and masks, fixed seed
`timescale 1ns/100ps
module lsal_core_test;
    reg         sys_clk, rst_b, meas_valid, pwm_drive_in, secondary_flag_summary;
    reg  [2:0]  meas_chan, c;
    reg  [7:0]  meas_value, meas_high_limit, meas_low_limit, m1, m2, q, v, hi, lo, a;
    reg  [6:0]  lvl;
    reg  [3:0]  p;
    reg  [15:0] e;
    wire [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire        reg_wr, reg_rd, alert_n, second_drive_output;
    integer     n_mismatch, checks_done, i;
    lsal_core i_lsal_core (.sys_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .meas_valid, .meas_chan, .meas_value, .meas_high_limit, .meas_low_limit,
        .tach_one_slow(lvl[1]), .tach_two_slow(lvl[2]), .tach_three_slow(lvl[3]),
        .tach_four_slow(lvl[4]), .diode_one_fault(lvl[5]), .diode_two_fault(lvl[6]),
        .critical_temp_limit(lvl[0]), .pwm_drive_in, .alert_n, .second_drive_output);
    lsal_host i_lsal_host (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
    function ool_f(input [2:0] c, input [7:0] v, h, l);
        ool_f = c > 3'h4 ? $signed(v) > $signed(h) || $signed(v) <= $signed(l) : v > h || v <= l;
    endfunction
    function [3:0] pos_f(input [2:0] c);
        pos_f = c < 3'h4 ? {1'b0, c} : (c == 3'h4 ? 4'h8 : {1'b0, c} - 4'h1);
    endfunction
    task chk(input string n, input [7:0] x, g);
        checks_done = checks_done + 1;
        if (g !== x) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0s exp %h got %h", n, x, g);
        end
    endtask
    task rd(input [7:0] ad, x);
        i_lsal_host.acc(1'b0, ad, 8'h00, q);
        chk("rdata", x, q);
    endtask
    task wr(input [7:0] ad, d);
        i_lsal_host.acc(1'b1, ad, d, q);
    endtask
    task meas(input [2:0] ch, input [7:0] mv, h, l);
        @(negedge sys_clk);
        meas_chan = ch;
        meas_value = mv;
        meas_high_limit = h;
        meas_low_limit = l;
        meas_valid = 1'b1;
        @(negedge sys_clk);
        meas_valid = 1'b0;
    endtask
    task give_verdict;
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        give_verdict;
    end
    initial begin
        {n_mismatch, checks_done, rst_b, meas_valid, pwm_drive_in, lvl} = 0;
        {meas_chan, meas_value, meas_high_limit, meas_low_limit} = 0;
        i = $urandom(32'h73a6);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        for (i = 0; i < 24; i = i + 1) begin
            m1 = $urandom;
            m2 = $urandom;
            wr(8'h74, m1);
            wr(8'h75, m2);
            {c, v, hi, lo} = $urandom;
            if (i < 8) begin
                c = i;
                hi = v;
                lo = v - {7'h00, i[0]};
            end
            secondary_flag_summary = ool_f(c, v, hi, lo);
            p = pos_f(c);
            e = {15'h0000, secondary_flag_summary} << p;
            a = p[3] ? 8'h42 : 8'h41;
            meas(c, v, hi, lo);
            rd(a, p[3] ? e[15:8] : e[7:0]);
            chk("alert_n", {7'h0, !(secondary_flag_summary && !(p[3] ? m2[0] & m1[7] : m1[p[2:0]]))},
                {7'h0, alert_n});
            meas(c, 8'h10, 8'h70, 8'h05);
            rd(a, p[3] ? e[15:8] : e[7:0]);
        end
        rd(8'h75, m2);
        wr(8'h74, 8'h00);
        wr(8'h75, 8'hff);
        for (i = 0; i < 7; i = i + 1) begin
            lvl = 7'h01 << i;
            @(negedge sys_clk);
            lvl = 7'h00;
            rd(8'h41, 8'h80);
            chk("alert_n", 8'h00, {7'h0, alert_n});
            rd(8'h42, 8'h02 << i);
            chk("alert_n", 8'h01, {7'h0, alert_n});
        end
        wr(8'h74, 8'h80);
        lvl = 7'h02;
        rd(8'h42, 8'h04);
        chk("alert_n", 8'h01, {7'h0, alert_n});
        lvl = 7'h00;
        rd(8'h42, 8'h04);
        rd(8'h42, 8'h00);
        wr(8'h74, 8'hff);
        lvl = 7'h7f;
        rd(8'h41, 8'h80);
        chk("alert_n", 8'h01, {7'h0, alert_n});
        rd(8'h74, 8'hff);
        lvl = 7'h00;
        rd(8'h42, 8'hfe);
        rd(8'h42, 8'h00);
        wr(8'h74, 8'h00);
        wr(8'h41, 8'hff);
        rd(8'h41, 8'h00);
        rd(8'h43, 8'h00);
        for (i = 0; i < 6; i = i + 1) begin
            pwm_drive_in = $urandom;
            @(negedge sys_clk);
            chk("pin", {7'h0, pwm_drive_in}, {7'h0, second_drive_output});
        end
        wr(8'h78, 8'hff);
        rd(8'h78, 8'h01);
        lvl = 7'h40;
        repeat (2) @(negedge sys_clk);
        chk("pin", 8'h00, {7'h0, second_drive_output});
        give_verdict;
    end
endmodule // lsal_core_test
